// ### hdl/bmx_exec.sv
/*
  Execution slice for multiplies, jumps, calls, returns, compares,
  skips and flag branches of an 8-bit core. Assumes the core presents
  operands, pc, flags and pointer on the start cycle, holds its flags
  until done, and serves stack bytes in the same cycle as pop.
*/
// Function
// - mixed sign multiply, pair 1:0, two cycles
// - fractional multiplies shift left, two cycles
// - pointer jump loads pc, two cycles
// - calls save return, three cycles
// - returns restore pc from stack, four
// - equal compare skips, one to three
// - compares set flags, store nothing, one
// - register bit skips, one to three
// - io bit skips, flags kept
// - generic flag branch to pc+k+1
// - carry branches, one or two cycles
// - same-or-higher on clear, lower on set
// - signed ge when n xor v clear
// - signed lt when n xor v set
// - half carry branches set and clear
// - transfer flag branches set and clear
// - overflow branches set and clear
`include "bmx_regs.svh"

module bmx_exec (
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               start_i,
  input  wire bmx_pkg::bmx_op_type op_i,
  input  wire logic [7:0]         rd_val_i,
  input  wire logic [7:0]         rr_val_i,
  input  wire logic [7:0]         imm_i,
  input  wire logic [2:0]         bit_sel_i,
  input  wire logic [7:0]         io_val_i,
  input  wire logic [15:0]        zptr_i,
  input  wire logic [15:0]        pc_i,
  input  wire logic [7:0]         status_flags_register_i,
  input  wire logic [11:0]        off_i,
  input  wire logic               next_two_word_i,
  input  wire logic [7:0]         stack_data_i,
  output logic                    ready_o,
  output logic                    done_o,
  output logic      [15:0]        pc_o,
  output logic      [15:0]        res_o,
  output logic                    res_we_o,
  output logic      [7:0]         status_flags_register_o,
  output logic                    status_flags_register_we_o,
  output logic                    push_o,
  output logic                    pop_o,
  output logic      [7:0]         stack_byte_o
);
  import bmx_pkg::*;

  bmx_exec_state_type q;
  bmx_exec_state_type d;
  logic [15:0]        mul_prod;
  logic               mul_carry;
  logic               take;

  // sign-extend the long relative offset
  function automatic logic [15:0] off12(input logic [11:0] k);
    off12 = {{4{k[11]}}, k};
  endfunction

  // sign-extend the short branch offset
  function automatic logic [15:0] off7(input logic [11:0] k);
    off7 = {{9{k[6]}}, k[6:0]};
  endfunction

  function automatic logic is_mul(input bmx_op_type op);
    is_mul = op inside {MIXED_SIGN_MULTIPLY, FRAC_UNSIGNED_MULTIPLY,
                        FRAC_SIGNED_MULTIPLY, FRAC_MIXED_MULTIPLY};
  endfunction

  function automatic logic is_call(input bmx_op_type op);
    is_call = op inside {RELATIVE_CALL, POINTER_CALL};
  endfunction

  function automatic logic is_ret(input bmx_op_type op);
    is_ret = op inside {SUBROUTINE_RETURN, INTERRUPT_RETURN};
  endfunction

  function automatic logic is_cmp(input bmx_op_type op);
    is_cmp = op inside {COMPARE, COMPARE_WITH_CARRY, COMPARE_IMMEDIATE};
  endfunction

  // subtract without storing; other flag bits pass through
  function automatic logic [7:0] cmp_flags(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic       cin,
                                           input logic       keep_z,
                                           input logic [7:0] s);
    logic [8:0] r;
    r = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    cmp_flags = s;
    cmp_flags[`BMX_SF_C] = r[8];
    cmp_flags[`BMX_SF_N] = r[7];
    cmp_flags[`BMX_SF_Z] = (r[7:0] == 8'h00) &
                           (keep_z ? s[`BMX_SF_Z] : 1'b1);
    cmp_flags[`BMX_SF_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    cmp_flags[`BMX_SF_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
  endfunction

  // branch condition per opcode; non-branches never take
  function automatic logic br_taken(input bmx_op_type op,
                                    input logic [7:0] s,
                                    input logic [2:0] sel);
    case (op)
      BRANCH_FLAG_SET:        br_taken = s[sel];
      BRANCH_FLAG_CLEAR:      br_taken = ~s[sel];
      BRANCH_CARRY_SET:       br_taken = s[`BMX_SF_C];
      BRANCH_CARRY_CLEAR:     br_taken = ~s[`BMX_SF_C];
      BRANCH_LOWER:           br_taken = s[`BMX_SF_C];
      BRANCH_SAME_OR_HIGHER:  br_taken = ~s[`BMX_SF_C];
      BRANCH_SIGNED_GE:       br_taken = ~(s[`BMX_SF_N] ^ s[`BMX_SF_V]);
      BRANCH_SIGNED_LT:       br_taken = s[`BMX_SF_N] ^ s[`BMX_SF_V];
      BRANCH_HALFCARRY_SET:   br_taken = s[`BMX_SF_H];
      BRANCH_HALFCARRY_CLEAR: br_taken = ~s[`BMX_SF_H];
      BRANCH_TRANSFER_SET:    br_taken = s[`BMX_SF_T];
      BRANCH_TRANSFER_CLEAR:  br_taken = ~s[`BMX_SF_T];
      BRANCH_OVERFLOW_SET:    br_taken = s[`BMX_SF_V];
      BRANCH_OVERFLOW_CLEAR:  br_taken = ~s[`BMX_SF_V];
      default:                br_taken = 1'b0;
    endcase
  endfunction

  assign take = start_i & ready_o;

  // multiplier latches its product on the start cycle
  bmx_mult u_mult (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (take),
    .a_i        (rd_val_i),
    .b_i        (rr_val_i),
    .a_signed_i (op_i != FRAC_UNSIGNED_MULTIPLY),
    .b_signed_i (op_i == FRAC_SIGNED_MULTIPLY),
    .frac_i     (op_i != MIXED_SIGN_MULTIPLY),
    .prod_o     (mul_prod),
    .carry_o    (mul_carry)
  );

  // next state: decode on start, then count down the cycles
  always_comb begin
    logic [2:0] cyc;
    logic       skip;
    cyc  = `BMX_CYC_ONE;
    skip = 1'b0;
    d = q;
    d.done    = 1'b0;
    d.res_we  = 1'b0;
    d.status_flags_register_we = 1'b0;
    case (q.state)
      ST_IDLE: begin
        if (start_i) begin
          d.op   = op_i;
          d.status_flags_register = status_flags_register_i;
          d.pc   = pc_i + 16'h0001;
          d.res  = pc_i + 16'h0001;
          d.stk  = d.res[7:0];
          case (op_i)
            MIXED_SIGN_MULTIPLY, FRAC_UNSIGNED_MULTIPLY,
            FRAC_SIGNED_MULTIPLY, FRAC_MIXED_MULTIPLY: begin
              cyc = `BMX_CYC_MUL;
            end
            RELATIVE_JUMP: begin
              d.pc = pc_i + off12(off_i) + 16'h0001;
              cyc  = `BMX_CYC_JUMP;
            end
            POINTER_JUMP: begin
              d.pc = zptr_i;
              cyc  = `BMX_CYC_JUMP;
            end
            RELATIVE_CALL: begin
              d.pc = pc_i + off12(off_i) + 16'h0001;
              cyc  = `BMX_CYC_CALL;
            end
            POINTER_CALL: begin
              d.pc = zptr_i;
              cyc  = `BMX_CYC_CALL;
            end
            SUBROUTINE_RETURN, INTERRUPT_RETURN: begin
              cyc = `BMX_CYC_RET;
            end
            COMPARE_SKIP_EQUAL: skip = (rd_val_i == rr_val_i);
            COMPARE: begin
              d.status_flags_register = cmp_flags(rd_val_i, rr_val_i, 1'b0, 1'b0, status_flags_register_i);
            end
            COMPARE_WITH_CARRY: begin
              d.status_flags_register = cmp_flags(rd_val_i, rr_val_i, status_flags_register_i[`BMX_SF_C],
                                 1'b1, status_flags_register_i);
            end
            COMPARE_IMMEDIATE: begin
              d.status_flags_register = cmp_flags(rd_val_i, imm_i, 1'b0, 1'b0, status_flags_register_i);
            end
            SKIP_REG_BIT_CLEAR: skip = ~rr_val_i[bit_sel_i];
            SKIP_REG_BIT_SET:   skip = rr_val_i[bit_sel_i];
            SKIP_IO_BIT_CLEAR:  skip = ~io_val_i[bit_sel_i];
            SKIP_IO_BIT_SET:    skip = io_val_i[bit_sel_i];
            default: begin
              if (br_taken(op_i, status_flags_register_i, bit_sel_i)) begin
                d.pc = pc_i + off7(off_i) + 16'h0001;
                cyc  = `BMX_CYC_BR_TAKEN;
              end
            end
          endcase
          // skip length follows next word count
          if (skip) begin
            d.pc = pc_i + (next_two_word_i ? 16'h0003 : 16'h0002);
            cyc  = next_two_word_i ? `BMX_CYC_SKIP_LONG
                                   : `BMX_CYC_SKIP_SHORT;
          end
          d.cnt = cyc - 3'h1;
          if (cyc == `BMX_CYC_ONE) begin
            d.done    = 1'b1;
            d.status_flags_register_we = is_cmp(op_i);
          end else begin
            d.state = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        d.cnt = q.cnt - 3'h1;
        // high byte pops first, then low
        if (is_ret(q.op) && q.cnt == 3'h3) begin
          d.pc[15:8] = stack_data_i;
        end
        if (is_ret(q.op) && q.cnt == 3'h2) begin
          d.pc[7:0] = stack_data_i;
        end
        // low byte pushed first, then high
        if (is_call(q.op)) begin
          d.stk = q.res[15:8];
        end
        if (q.cnt == 3'h1) begin
          d.done  = 1'b1;
          d.state = ST_IDLE;
          if (is_mul(q.op)) begin
            d.res               = mul_prod;
            d.res_we            = 1'b1;
            d.status_flags_register[`BMX_SF_C]   = mul_carry;
            d.status_flags_register[`BMX_SF_Z]   = (mul_prod == 16'h0000);
            d.status_flags_register_we           = 1'b1;
          end
        end
      end
      default: d = `BMX_STATE_RST;
    endcase
  end

  // state register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= `BMX_STATE_RST;
    end else begin
      q <= d;
    end
  end

  // outputs; pop strobe decodes the count, push only state and op, no extra latency
  assign ready_o      = (q.state == ST_IDLE);
  assign done_o       = q.done;
  assign pc_o         = q.pc;
  assign res_o        = q.res;
  assign res_we_o     = q.res_we;
  assign status_flags_register_o       = q.status_flags_register;
  assign status_flags_register_we_o    = q.status_flags_register_we;
  assign push_o       = (q.state == ST_RUN) && is_call(q.op);
  assign pop_o        = (q.state == ST_RUN) && is_ret(q.op) &&
                        (q.cnt != 3'h1);
  assign stack_byte_o = q.stk;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_mul_two;
    take && op_i == MIXED_SIGN_MULTIPLY |->
      ##1 !done_o ##1 done_o && res_we_o && status_flags_register_we_o;
  endproperty
  a_mul_two: assert property (p_mul_two)
    else $error("mixed multiply not done in two cycles");

  property p_frac_shift;
    take && op_i == FRAC_UNSIGNED_MULTIPLY |-> ##2
      res_o == 16'({8'h00, $past(rd_val_i, 2)} *
                   {8'h00, $past(rr_val_i, 2)} << 1);
  endproperty
  a_frac_shift: assert property (p_frac_shift)
    else $error("fractional product not shifted");

  property p_ptr_jump;
    take && op_i == POINTER_JUMP |->
      ##2 done_o && pc_o == $past(zptr_i, 2) && !status_flags_register_we_o;
  endproperty
  a_ptr_jump: assert property (p_ptr_jump)
    else $error("pointer jump wrong");

  property p_call;
    take && is_call(op_i) |->
      ##1 push_o && !done_o ##1 push_o ##1 done_o && !status_flags_register_we_o;
  endproperty
  a_call: assert property (p_call)
    else $error("call sequence wrong");

  property p_ret;
    take && is_ret(op_i) |-> ##1 pop_o ##1 pop_o ##1 !done_o ##1
      done_o && !status_flags_register_we_o &&
      pc_o == {$past(stack_data_i, 3), $past(stack_data_i, 2)};
  endproperty
  a_ret: assert property (p_ret)
    else $error("return sequence wrong");

  property p_compare_skip_equal_miss;
    take && op_i == COMPARE_SKIP_EQUAL && rd_val_i != rr_val_i |->
      ##1 done_o && pc_o == $past(pc_i) + 16'h0001;
  endproperty
  a_compare_skip_equal_miss: assert property (p_compare_skip_equal_miss)
    else $error("unequal compare should not skip");

  property p_cmp_one;
    take && is_cmp(op_i) |-> ##1 done_o && status_flags_register_we_o && !res_we_o;
  endproperty
  a_cmp_one: assert property (p_cmp_one)
    else $error("compare not one cycle");

  property p_reg_skip;
    take && op_i == SKIP_REG_BIT_SET && rr_val_i[bit_sel_i] &&
      next_two_word_i |-> ##1 !done_o ##1 !done_o ##1
      done_o && pc_o == $past(pc_i, 3) + 16'h0003;
  endproperty
  a_reg_skip: assert property (p_reg_skip)
    else $error("register bit skip wrong");

  property p_io_skip;
    take && op_i == SKIP_IO_BIT_CLEAR && !io_val_i[bit_sel_i] &&
      !next_two_word_i |-> ##2 done_o && !status_flags_register_we_o &&
      pc_o == $past(pc_i, 2) + 16'h0002;
  endproperty
  a_io_skip: assert property (p_io_skip)
    else $error("io bit skip wrong");

  property p_flag_br;
    take && op_i == BRANCH_FLAG_SET && status_flags_register_i[bit_sel_i] |->
      ##2 done_o && pc_o == $past(pc_i, 2) + off7($past(off_i, 2)) + 16'h0001;
  endproperty
  a_flag_br: assert property (p_flag_br)
    else $error("flag branch target wrong");

  property p_carry_br;
    take && op_i == BRANCH_CARRY_SET && !status_flags_register_i[`BMX_SF_C] |->
      ##1 done_o && pc_o == $past(pc_i) + 16'h0001;
  endproperty
  a_carry_br: assert property (p_carry_br)
    else $error("carry branch taken on clear");

  property p_soh_br;
    take && op_i == BRANCH_SAME_OR_HIGHER && !status_flags_register_i[`BMX_SF_C] |->
      ##1 !done_o ##1 done_o;
  endproperty
  a_soh_br: assert property (p_soh_br)
    else $error("same-or-higher not taken");

  property p_ge_br;
    take && op_i == BRANCH_SIGNED_GE &&
      (status_flags_register_i[`BMX_SF_N] ^ status_flags_register_i[`BMX_SF_V]) |-> ##1 done_o;
  endproperty
  a_ge_br: assert property (p_ge_br)
    else $error("signed ge taken wrongly");

  property p_lt_br;
    take && op_i == BRANCH_SIGNED_LT &&
      (status_flags_register_i[`BMX_SF_N] ^ status_flags_register_i[`BMX_SF_V]) |-> ##2 done_o;
  endproperty
  a_lt_br: assert property (p_lt_br)
    else $error("signed lt not taken");

  property p_hc_br;
    take && op_i == BRANCH_HALFCARRY_CLEAR && status_flags_register_i[`BMX_SF_H] |->
      ##1 done_o && pc_o == $past(pc_i) + 16'h0001;
  endproperty
  a_hc_br: assert property (p_hc_br)
    else $error("half carry branch wrong");

  property p_t_br;
    take && op_i == BRANCH_TRANSFER_SET && status_flags_register_i[`BMX_SF_T] |->
      ##1 !done_o ##1 done_o;
  endproperty
  a_t_br: assert property (p_t_br)
    else $error("transfer branch not taken");

  property p_v_br;
    take && op_i == BRANCH_OVERFLOW_CLEAR && status_flags_register_i[`BMX_SF_V] |->
      ##1 done_o && !status_flags_register_we_o;
  endproperty
  a_v_br: assert property (p_v_br)
    else $error("overflow branch wrong");

  c_mul: cover property (take && op_i == FRAC_MIXED_MULTIPLY ##2 done_o);
  c_call: cover property (take && op_i == RELATIVE_CALL ##3 done_o);
  c_ret: cover property (take && op_i == INTERRUPT_RETURN ##4 done_o);
  c_skip: cover property (take && op_i == COMPARE_SKIP_EQUAL &&
                          rd_val_i == rr_val_i ##3 done_o);

endmodule

// ### hdl/bmx_mult.sv
/*
  Registered 8x8 multiplier with per-operand sign and fractional shift.
  Assumes operands are stable in the cycle load_i is high.
*/
module bmx_mult (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        load_i,
  input  wire logic [7:0]  a_i,
  input  wire logic [7:0]  b_i,
  input  wire logic        a_signed_i,
  input  wire logic        b_signed_i,
  input  wire logic        frac_i,
  output logic      [15:0] prod_o,
  output logic             carry_o
);
  import bmx_pkg::*;

  bmx_mult_state_type q;
  bmx_mult_state_type d;

  // product and carry; carry is bit 15 before the fractional shift
  always_comb begin
    logic signed [17:0] p;
    p = '0;
    d = q;
    p = $signed({a_signed_i & a_i[7], a_i}) *
        $signed({b_signed_i & b_i[7], b_i});
    if (load_i) begin
      d.carry = p[15];
      d.prod  = frac_i ? {p[14:0], 1'b0} : p[15:0];
    end
  end

  // state register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign prod_o  = q.prod;
  assign carry_o = q.carry;

endmodule

// ### shared/bmx_pkg.sv
/*
  Types shared by the execution slice and its multiplier.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bmx_pkg;

  // operations handled by this slice
  typedef enum logic [4:0] {
    MIXED_SIGN_MULTIPLY, FRAC_UNSIGNED_MULTIPLY, FRAC_SIGNED_MULTIPLY,
    FRAC_MIXED_MULTIPLY, RELATIVE_JUMP, POINTER_JUMP, RELATIVE_CALL,
    POINTER_CALL, SUBROUTINE_RETURN, INTERRUPT_RETURN, COMPARE_SKIP_EQUAL,
    COMPARE, COMPARE_WITH_CARRY, COMPARE_IMMEDIATE, SKIP_REG_BIT_CLEAR,
    SKIP_REG_BIT_SET, SKIP_IO_BIT_CLEAR, SKIP_IO_BIT_SET, BRANCH_FLAG_SET,
    BRANCH_FLAG_CLEAR, BRANCH_CARRY_SET, BRANCH_CARRY_CLEAR,
    BRANCH_SAME_OR_HIGHER, BRANCH_LOWER, BRANCH_SIGNED_GE, BRANCH_SIGNED_LT,
    BRANCH_HALFCARRY_SET, BRANCH_HALFCARRY_CLEAR, BRANCH_TRANSFER_SET,
    BRANCH_TRANSFER_CLEAR, BRANCH_OVERFLOW_SET, BRANCH_OVERFLOW_CLEAR
  } bmx_op_type;

  typedef enum logic {ST_IDLE, ST_RUN} bmx_fsm_type;

  typedef struct packed {
    bmx_fsm_type state;
    logic [2:0]  cnt;
    bmx_op_type  op;
    logic [15:0] pc;
    logic [7:0]  status_flags_register;
    logic [15:0] res;
    logic [7:0]  stk;
    logic        done;
    logic        res_we;
    logic        status_flags_register_we;
  } bmx_exec_state_type;

  typedef struct packed {
    logic [15:0] prod;
    logic        carry;
  } bmx_mult_state_type;

endpackage

// ### shared/bmx_regs.svh
/*
  Timing counts and status flag positions for the branch and multiply
  execution slice. Assumes inclusion by bare name, once per unit.
*/
`ifndef BMX_REGS_SVH
`define BMX_REGS_SVH

// cycles per instruction group
`define BMX_CYC_MUL        3'h2
`define BMX_CYC_JUMP       3'h2
`define BMX_CYC_CALL       3'h3
`define BMX_CYC_RET        3'h4
`define BMX_CYC_ONE        3'h1
`define BMX_CYC_BR_TAKEN   3'h2
`define BMX_CYC_SKIP_SHORT 3'h2
`define BMX_CYC_SKIP_LONG  3'h3

// status flag bit positions
`define BMX_SF_C 0
`define BMX_SF_Z 1
`define BMX_SF_N 2
`define BMX_SF_V 3
`define BMX_SF_S 4
`define BMX_SF_H 5
`define BMX_SF_T 6
`define BMX_SF_I 7

// state after reset: idle, all fields cleared
`define BMX_STATE_RST '0

`endif

// ### tb/tb_branch_and_multiply_exec.sv
/*
  Self-checking bench for the branch and multiply execution slice.
  Assumes bmx_pkg is compiled first and bmx_regs.svh is on the path.
*/
`include "bmx_regs.svh"

module tb_branch_and_multiply_exec import bmx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        start_i = 1'b0;
  bmx_op_type  op_i = MIXED_SIGN_MULTIPLY;
  logic [7:0]  rd_val_i = '0, rr_val_i = '0, imm_i = '0, io_val_i = '0;
  logic [7:0]  status_flags_register_i = '0, stack_data_i = '0, st_hi, st_lo;
  logic [2:0]  bit_sel_i = '0;
  logic [15:0] zptr_i = '0, pc_i = '0;
  logic [11:0] off_i = '0;
  logic        next_two_word_i = 1'b0;
  logic        ready_o, done_o, res_we_o, status_flags_register_we_o, push_o, pop_o;
  logic [15:0] pc_o, res_o;
  logic [7:0]  status_flags_register_o, stack_byte_o;
  // model expectations
  logic [15:0] e_pc, e_res, e_push;
  logic [7:0]  e_status_flags_register;
  logic        e_rwe, e_swe;
  int          e_cyc;
  int          seed = 32'hcc1b_6a0e;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cyc = 0;

  bmx_exec u_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .start_i(start_i),
    .op_i(op_i), .rd_val_i(rd_val_i), .rr_val_i(rr_val_i), .imm_i(imm_i),
    .bit_sel_i(bit_sel_i), .io_val_i(io_val_i), .zptr_i(zptr_i),
    .pc_i(pc_i), .status_flags_register_i(status_flags_register_i), .off_i(off_i),
    .next_two_word_i(next_two_word_i), .stack_data_i(stack_data_i),
    .ready_o(ready_o), .done_o(done_o), .pc_o(pc_o), .res_o(res_o),
    .res_we_o(res_we_o), .status_flags_register_o(status_flags_register_o), .status_flags_register_we_o(status_flags_register_we_o),
    .push_o(push_o), .pop_o(pop_o), .stack_byte_o(stack_byte_o)
  );

  // 125 MHz core clock
  always #4 core_clk_i = ~core_clk_i;

  // hang guard, run needs about 1.8k cycles
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // reference model from the current inputs
  task automatic model();
    logic [15:0] p;
    logic [8:0]  df;
    logic [4:0]  hf;
    logic [7:0]  s;
    logic        cin, skp, cnd;
    e_pc = pc_i + 16'h0001;
    e_cyc = 1;
    e_rwe = 1'b0;
    e_swe = 1'b0;
    e_status_flags_register = status_flags_register_i;
    e_push = 16'h0000;
    skp = 1'b0;
    cnd = 1'b0;
    if (op_i <= FRAC_MIXED_MULTIPLY) begin
      p = $signed({op_i != FRAC_UNSIGNED_MULTIPLY && rd_val_i[7], rd_val_i})
        * $signed({op_i == FRAC_SIGNED_MULTIPLY && rr_val_i[7], rr_val_i});
      e_res = (op_i == MIXED_SIGN_MULTIPLY) ? p : {p[14:0], 1'b0};
      e_status_flags_register[`BMX_SF_C] = p[15];
      e_status_flags_register[`BMX_SF_Z] = (e_res == 16'h0000);
      e_cyc = 2;
      e_rwe = 1'b1;
      e_swe = 1'b1;
    end
    if (op_i inside {COMPARE, COMPARE_WITH_CARRY, COMPARE_IMMEDIATE}) begin
      s = (op_i == COMPARE_IMMEDIATE) ? imm_i : rr_val_i;
      cin = (op_i == COMPARE_WITH_CARRY) && status_flags_register_i[`BMX_SF_C];
      df = {1'b0, rd_val_i} - {1'b0, s} - 9'(cin);
      hf = {1'b0, rd_val_i[3:0]} - {1'b0, s[3:0]} - 5'(cin);
      e_status_flags_register[`BMX_SF_C] = df[8];
      e_status_flags_register[`BMX_SF_H] = hf[4];
      e_status_flags_register[`BMX_SF_N] = df[7];
      e_status_flags_register[`BMX_SF_V] = (rd_val_i[7] != s[7]) && (df[7] != rd_val_i[7]);
      e_status_flags_register[`BMX_SF_Z] = (df[7:0] == 8'h00) &&
        (op_i != COMPARE_WITH_CARRY || status_flags_register_i[`BMX_SF_Z]);
      e_swe = 1'b1;
    end
    case (op_i)
      RELATIVE_JUMP: e_pc = pc_i + {{4{off_i[11]}}, off_i} + 16'h0001;
      POINTER_JUMP: e_pc = zptr_i;
      RELATIVE_CALL: e_pc = pc_i + {{4{off_i[11]}}, off_i} + 16'h0001;
      POINTER_CALL: e_pc = zptr_i;
      SUBROUTINE_RETURN, INTERRUPT_RETURN: e_pc = {st_hi, st_lo};
      COMPARE_SKIP_EQUAL: skp = (rd_val_i == rr_val_i);
      SKIP_REG_BIT_CLEAR: skp = !rr_val_i[bit_sel_i];
      SKIP_REG_BIT_SET: skp = rr_val_i[bit_sel_i];
      SKIP_IO_BIT_CLEAR: skp = !io_val_i[bit_sel_i];
      SKIP_IO_BIT_SET: skp = io_val_i[bit_sel_i];
      BRANCH_FLAG_SET: cnd = status_flags_register_i[bit_sel_i];
      BRANCH_FLAG_CLEAR: cnd = !status_flags_register_i[bit_sel_i];
      BRANCH_CARRY_SET, BRANCH_LOWER: cnd = status_flags_register_i[`BMX_SF_C];
      BRANCH_CARRY_CLEAR, BRANCH_SAME_OR_HIGHER: cnd = !status_flags_register_i[`BMX_SF_C];
      BRANCH_SIGNED_GE: cnd = !(status_flags_register_i[`BMX_SF_N] ^ status_flags_register_i[`BMX_SF_V]);
      BRANCH_SIGNED_LT: cnd = status_flags_register_i[`BMX_SF_N] ^ status_flags_register_i[`BMX_SF_V];
      BRANCH_HALFCARRY_SET: cnd = status_flags_register_i[`BMX_SF_H];
      BRANCH_HALFCARRY_CLEAR: cnd = !status_flags_register_i[`BMX_SF_H];
      BRANCH_TRANSFER_SET: cnd = status_flags_register_i[`BMX_SF_T];
      BRANCH_TRANSFER_CLEAR: cnd = !status_flags_register_i[`BMX_SF_T];
      BRANCH_OVERFLOW_SET: cnd = status_flags_register_i[`BMX_SF_V];
      BRANCH_OVERFLOW_CLEAR: cnd = !status_flags_register_i[`BMX_SF_V];
      default: ;
    endcase
    if (op_i inside {RELATIVE_JUMP, POINTER_JUMP}) e_cyc = 2;
    if (op_i inside {RELATIVE_CALL, POINTER_CALL}) begin
      e_cyc = 3;
      e_push = pc_i + 16'h0001;
    end
    if (op_i inside {SUBROUTINE_RETURN, INTERRUPT_RETURN}) e_cyc = 4;
    // skip over one or two words
    if (skp) begin
      e_cyc = next_two_word_i ? 3 : 2;
      e_pc = pc_i + (next_two_word_i ? 16'h0003 : 16'h0002);
    end
    if (cnd) begin
      e_cyc = 2;
      e_pc = pc_i + {{9{off_i[6]}}, off_i[6:0]} + 16'h0001;
    end
  endtask

  // one instruction: random operands, corner cases by index j
  task automatic run_op(input bmx_op_type op, input int j);
    int          n;
    logic [15:0] pushed;
    pushed = 16'h0000;
    // odd j starts in the done cycle of the op before, as order allows
    if (j % 2 == 0) begin
      @(negedge core_clk_i);
      chk_bit(done_o, 1'b0);
    end
    op_i = op;
    {rd_val_i, rr_val_i, imm_i, io_val_i} = $random(seed);
    {zptr_i, pc_i} = $random(seed);
    {status_flags_register_i, off_i, bit_sel_i, next_two_word_i, st_hi} = $random(seed);
    st_lo = 8'($random(seed));
    if (j % 4 == 0) rr_val_i = rd_val_i;
    if (j % 4 == 1) imm_i = rd_val_i;
    if (j == 2) {rd_val_i, rr_val_i, off_i} = {16'h8080, 12'h840};
    if (j == 3) {rd_val_i, rr_val_i, pc_i} = {16'hffff, 16'hffff};
    model();
    start_i = 1'b1;
    @(negedge core_clk_i);
    start_i = 1'b0;
    // stack bytes offered only while popped, else toggling junk
    for (n = 1; n < 9 && done_o !== 1'b1; n++) begin
      chk_bit(ready_o, 1'b0);
      if (push_o === 1'b1) pushed = {stack_byte_o, pushed[15:8]};
      if (pop_o === 1'b1) stack_data_i = (n == 1) ? st_hi : st_lo;
      else stack_data_i = ~stack_data_i;
      @(negedge core_clk_i);
    end
    chk_val(16'(n), 16'(e_cyc));
    chk_val(pc_o, e_pc);
    chk_bit(res_we_o, e_rwe);
    chk_bit(status_flags_register_we_o, e_swe);
    chk_val(pushed, e_push);
    if (e_rwe) chk_val(res_o, e_res);
    if (e_swe) chk_val({8'h00, status_flags_register_o}, {8'h00, e_status_flags_register});
  endtask

  task automatic group(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      for (int j = 0; j < 24; j++) run_op(bmx_op_type'(i), j);
      $display("test %s ended", op_i.name());
    end
  endtask

  // main sequence
  initial begin
    repeat (10) @(negedge core_clk_i);
    chk_bit(ready_o, 1'b1);
    chk_bit(done_o, 1'b0);
    chk_val(pc_o, 16'h0000);
    rst_n_i = 1'b1;
    group(0, 3);
    group(4, 9);
    group(10, 13);
    group(14, 17);
    group(18, 31);
    // reset in mid-call drops the pending push
    @(negedge core_clk_i);
    op_i = POINTER_CALL;
    start_i = 1'b1;
    @(negedge core_clk_i);
    start_i = 1'b0;
    rst_n_i = 1'b0;
    @(negedge core_clk_i);
    chk_bit(push_o, 1'b0);
    chk_bit(ready_o, 1'b1);
    chk_bit(done_o, 1'b0);
    rst_n_i = 1'b1;
    run_op(RELATIVE_CALL, 3);
    $display("test mid-run reset ended");
    close_out();
  end
endmodule
